/* File: pkg/mei_cfg.svh */
// Constants of the motion event and interrupt control block.
// Assumes inclusion by bare name from the package and the design modules.
// Summary of operation
// [R1] Define-home command zeroes the absolute position register.
// [R2] Define-home leaves the ongoing move's target untouched unless motion restarts.
// [R3] Interrupt output asserts only for flags whose enable bit is one.
// [R4] Status flags show their conditions whatever the enable mask holds.
// [R5] Arm-index command latches position at next index pulse, sets bit 3.
// [R6] Capture happens when both phases and index are low together.
// [R7] Threshold commands carry two bytes, high byte first, value 0 to 7FFF.
// [R8] Error magnitude above threshold sets status bit 5.
// [R9] Stop-mode threshold also sets bit 5 and forces motor to zero code.
// [R10] Absolute breakpoint, four bytes; bit 6 set when position reaches it.
// [R11] Relative breakpoint is offset from commanded target; sets bit 6 too.
// [R12] Host keeps relative breakpoint plus target inside position range.
// [R13] Enable command: low byte bits 1..6 enable interrupts, others ignored.
// [R14] Enable and clear words share one bit layout, bits 1 to 6.
// [R15] Clear command: each zero in bits 1..6 clears that flag.
// [R16] Status byte bits 1..6 report the six event conditions.
// [R17] Host may clear flags singly, in its own priority order.
// [R18] Zero motor code is 80 hex narrow, 800 hex wide.
// [R19] Command bytes written while busy are ignored.
// [R20] Flags stay set until cleared; interrupt holds while any enabled flag set.
// [R21] New threshold or breakpoint applies from next servo sample.
`ifndef MEI_CFG_SVH
`define MEI_CFG_SVH
// ****************************************
// Command codes
// ****************************************
`define MEI_CMD_START 8'h01
`define MEI_CMD_HOME 8'h02
`define MEI_CMD_ARM_IDX 8'h03
`define MEI_CMD_NARROW 8'h05
`define MEI_CMD_WIDE 8'h06
`define MEI_CMD_ERR_STOP 8'h1A
`define MEI_CMD_ERR_INT 8'h1B
`define MEI_CMD_ENABLE 8'h1C
`define MEI_CMD_CLEAR 8'h1D
`define MEI_CMD_BP_ABS 8'h20
`define MEI_CMD_BP_REL 8'h21
// ****************************************
// Data byte counts
// ****************************************
`define MEI_LEN_NONE 3'h0
`define MEI_LEN_WORD 3'h2
`define MEI_LEN_LONG 3'h4
// ****************************************
// Flag positions and layout
// ****************************************
`define MEI_FLG_LSB 1
`define MEI_FLG_MSB 6
`define MEI_FLG_CMDERR 0
`define MEI_FLG_TRAJ 1
`define MEI_FLG_INDEX 2
`define MEI_FLG_WRAP 3
`define MEI_FLG_POSERR 4
`define MEI_FLG_BREAK 5
`define MEI_THR_MSB 14
// ****************************************
// Reset values and codes
// ****************************************
`define MEI_ENABLE_RST 6'h00
`define MEI_ZERO_NARROW 12'h080
`define MEI_ZERO_WIDE 12'h800
// ****************************************
// Timing
// ****************************************
`define MEI_CLK_MHZ 25
`define MEI_BUSY_NS 2000
`define MEI_BUSY_CYC ((`MEI_BUSY_NS * `MEI_CLK_MHZ + 999) / 1000)
`endif

/* File: pkg/mei_pkg.sv */
// Types of the motion event and interrupt control block.
// Assumes mei_cfg.svh on the include path.
`include "mei_cfg.svh"
package mei_pkg;
  // Synchroniser state, three stages and the settled value
  typedef struct packed {
    logic [10:0] s1;
    logic [10:0] s2;
    logic [10:0] s3;
    logic [10:0] q;
  } mei_sync_t;

  // Whole state of the controller
  typedef struct packed {
    logic wr_q;
    logic pa;
    logic pb;
    logic [7:0] busy_cnt;
    logic [7:0] cmd;
    logic [2:0] left;
    logic [23:0] shift;
    logic [31:0] abs_pos;
    logic [31:0] index_pos;
    logic idx_armed;
    logic [14:0] thresh;
    logic thr_valid;
    logic stop_mode;
    logic stopped;
    logic [31:0] bp_pos;
    logic bp_armed;
    logic wide;
    logic [5:0] enable;
    logic [5:0] flags;
    logic [7:0] status;
    logic irq;
    logic [11:0] motor;
    logic home_evt;
  } mei_state_t;
endpackage : mei_pkg

/* File: core/mei_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
module mei_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Pins and settled values
  input wire logic [10:0] pin,
  output logic [10:0] q
);
  mei_pkg::mei_sync_t st_r;
  mei_pkg::mei_sync_t st_nxt;

  // Value moves only when stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 11; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  // Idle level of all pins is high
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;
endmodule : mei_sync

/* File: core/mei_ctrl.sv */
// Event flags, interrupt gating and event detectors of the motion controller.
// Assumes host port and encoder pins are asynchronous; loop values are on ref_clk.
`timescale 1ns/1ps
`include "mei_cfg.svh"
module mei_ctrl #(
  parameter int BUSY_CYC = `MEI_BUSY_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host byte port pins
  input wire logic host_wr_n,
  input wire logic host_ps_n,
  input wire logic [7:0] host_d,
  // Encoder pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_idx_n,
  // Servo loop values
  input wire logic sample_tick,
  input wire logic signed [15:0] pos_error,
  input wire logic [31:0] target_pos,
  input wire logic [11:0] motor_in,
  input wire logic traj_done,
  input wire logic wrap_evt,
  // Host visible results
  output logic [7:0] status_byte,
  output logic host_irq,
  output logic [31:0] index_pos,
  // Position and motor
  output logic [31:0] abs_pos,
  output logic home_evt,
  output logic [11:0] motor_out
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [10:0] pins_q;
  logic q_wr_n;
  logic q_ps_n;
  logic [7:0] q_d;
  logic q_a;
  logic q_b;
  logic q_idx_n;

  mei_sync u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin({host_wr_n, host_ps_n, 1'b1, host_d}), // Bit 8 is a spare, held high
    .q(pins_q)
  );

  // Encoder phases and index pass a second copy of the same filter, on their own pins
  logic [2:0] enc_q;
  logic [7:0] pins_unused;
  mei_sync u_enc (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin({8'hFF, enc_a, enc_b, enc_idx_n}),
    .q({pins_unused, enc_q})
  );

  assign q_wr_n = pins_q[10];
  assign q_ps_n = pins_q[9];
  assign q_d = pins_q[7:0];
  assign q_a = enc_q[2];
  assign q_b = enc_q[1];
  assign q_idx_n = enc_q[0];

  // ****************************************
  // Functions
  // ****************************************
  // Data bytes that follow each command code
  function automatic logic [2:0] cmd_len(input logic [7:0] c);
    case (c)
      `MEI_CMD_ERR_STOP, `MEI_CMD_ERR_INT, `MEI_CMD_ENABLE, `MEI_CMD_CLEAR:
        cmd_len = `MEI_LEN_WORD;
      `MEI_CMD_BP_ABS, `MEI_CMD_BP_REL: cmd_len = `MEI_LEN_LONG;
      default: cmd_len = `MEI_LEN_NONE;
    endcase
  endfunction : cmd_len

  // Known codes; unknown ones raise the command error flag
  function automatic logic cmd_known(input logic [7:0] c);
    cmd_known = (cmd_len(c) != `MEI_LEN_NONE) || (c == `MEI_CMD_START) ||
      (c == `MEI_CMD_HOME) || (c == `MEI_CMD_ARM_IDX) ||
      (c == `MEI_CMD_NARROW) || (c == `MEI_CMD_WIDE);
  endfunction : cmd_known

  // Quadrature step from old and new phases, two's complement
  function automatic logic [1:0] quad_step(input logic [3:0] ab);
    case (ab)
      4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'h1;
      4'h2, 4'hB, 4'hD, 4'h4: quad_step = 2'h3;
      default: quad_step = 2'h0;
    endcase
  endfunction : quad_step

  // ****************************************
  // Next state
  // ****************************************
  mei_pkg::mei_state_t st_r;
  mei_pkg::mei_state_t st_nxt;
  logic wr_fall;
  logic cmd_byte;
  logic [31:0] word;
  logic [16:0] err_mag;
  logic [5:0] set_v;
  logic [5:0] clr_v;
  logic [1:0] step;

  always_comb begin
    st_nxt = st_r;
    set_v = 6'h00;
    clr_v = 6'h00;
    st_nxt.home_evt = 1'b0;
    st_nxt.wr_q = q_wr_n;
    wr_fall = st_r.wr_q & ~q_wr_n;
    cmd_byte = wr_fall & ~q_ps_n;
    word = {st_r.shift, q_d};
    err_mag = pos_error[15] ? 17'(-$signed({pos_error[15], pos_error}))
                            : {1'b0, pos_error};
    // Quadrature counting of the absolute position
    step = quad_step({st_r.pa, st_r.pb, q_a, q_b});
    st_nxt.pa = q_a;
    st_nxt.pb = q_b;
    st_nxt.abs_pos = st_r.abs_pos + {{30{step[1]}}, step};
    if (st_r.busy_cnt != 8'h00) begin
      st_nxt.busy_cnt = st_r.busy_cnt - 8'h01;
    end
    // Host bytes; nothing is taken while busy [R19]
    if (wr_fall && st_r.busy_cnt == 8'h00) begin
      if (!q_ps_n) begin
        st_nxt.cmd = q_d;
        st_nxt.left = cmd_len(q_d);
        st_nxt.busy_cnt = 8'(BUSY_CYC);
        if (!cmd_known(q_d)) begin
          set_v[`MEI_FLG_CMDERR] = 1'b1;
        end
        unique case (q_d)
          // Home zeroes position; target input is left alone [R1] [R2]
          `MEI_CMD_HOME: begin
            st_nxt.abs_pos = 32'h0000_0000;
            st_nxt.home_evt = 1'b1;
          end
          `MEI_CMD_ARM_IDX: st_nxt.idx_armed = 1'b1; // [R5]
          `MEI_CMD_NARROW: st_nxt.wide = 1'b0;
          `MEI_CMD_WIDE: st_nxt.wide = 1'b1;
          `MEI_CMD_START: st_nxt.stopped = 1'b0;
          default: ;
        endcase
      end else if (st_r.left != `MEI_LEN_NONE) begin
        st_nxt.shift = word[23:0];
        st_nxt.left = st_r.left - 3'h1;
        // Busy after the second byte of each pair
        if (st_r.left[0] == 1'b1) begin
          st_nxt.busy_cnt = 8'(BUSY_CYC);
        end
        if (st_r.left == 3'h1) begin
          // Values land now; compared at next sample [R21]
          unique case (st_r.cmd)
            `MEI_CMD_ERR_INT, `MEI_CMD_ERR_STOP: begin
              st_nxt.thresh = word[`MEI_THR_MSB:0]; // [R7]
              st_nxt.thr_valid = 1'b1;
              st_nxt.stop_mode = (st_r.cmd == `MEI_CMD_ERR_STOP);
            end
            `MEI_CMD_BP_ABS: begin
              st_nxt.bp_pos = word; // [R10]
              st_nxt.bp_armed = 1'b1;
            end
            `MEI_CMD_BP_REL: begin
              // Host keeps the sum in range, no wrap check here [R11] [R12]
              st_nxt.bp_pos = target_pos + word;
              st_nxt.bp_armed = 1'b1;
            end
            `MEI_CMD_ENABLE: st_nxt.enable = word[`MEI_FLG_MSB:`MEI_FLG_LSB]; // [R13] [R14]
            `MEI_CMD_CLEAR: clr_v = ~word[`MEI_FLG_MSB:`MEI_FLG_LSB]; // [R15] [R17]
            default: ;
          endcase
        end
      end
    end
    // Index capture on all three inputs low [R5] [R6]
    if (st_r.idx_armed && !q_a && !q_b && !q_idx_n) begin
      st_nxt.index_pos = st_r.abs_pos;
      st_nxt.idx_armed = 1'b0;
      set_v[`MEI_FLG_INDEX] = 1'b1;
    end
    // Error and breakpoint checks once per servo sample
    if (sample_tick) begin
      if (st_r.thr_valid && err_mag > {2'b00, st_r.thresh}) begin
        set_v[`MEI_FLG_POSERR] = 1'b1; // [R8]
        if (st_r.stop_mode) begin
          st_nxt.stopped = 1'b1; // [R9]
        end
      end
      if (st_r.bp_armed && st_r.abs_pos == st_r.bp_pos) begin
        set_v[`MEI_FLG_BREAK] = 1'b1; // [R10] [R11]
        st_nxt.bp_armed = 1'b0;
      end
    end
    set_v[`MEI_FLG_TRAJ] = set_v[`MEI_FLG_TRAJ] | traj_done;
    set_v[`MEI_FLG_WRAP] = set_v[`MEI_FLG_WRAP] | wrap_evt;
    // Sticky flags, an arriving event beats a clear [R20]
    st_nxt.flags = (st_r.flags & ~clr_v) | set_v;
    // Status shows flags whatever the mask [R4] [R16]
    st_nxt.status = {1'b0, st_nxt.flags, st_nxt.busy_cnt != 8'h00};
    st_nxt.irq = |(st_nxt.flags & st_nxt.enable); // [R3] [R20]
    // Stopped motor sits at the half-scale zero code [R9] [R18]
    if (st_nxt.stopped) begin
      st_nxt.motor = st_nxt.wide ? `MEI_ZERO_WIDE : `MEI_ZERO_NARROW;
    end else begin
      st_nxt.motor = motor_in;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Motor rests at the narrow zero code out of reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.wr_q <= 1'b1;
      st_r.enable <= `MEI_ENABLE_RST;
      st_r.motor <= `MEI_ZERO_NARROW;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status_byte = st_r.status;
  assign host_irq = st_r.irq;
  assign index_pos = st_r.index_pos;
  assign abs_pos = st_r.abs_pos;
  assign home_evt = st_r.home_evt;
  assign motor_out = st_r.motor;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Plain helper signals, so that past values always name a signal
  logic [5:0] kept_v;
  logic [5:0] race_v;
  logic [5:0] drop_v;
  logic [5:0] low_field;
  logic [14:0] thr_word;
  assign kept_v = st_r.flags & ~clr_v;
  assign race_v = set_v & clr_v;
  assign drop_v = clr_v & ~set_v;
  assign low_field = q_d[`MEI_FLG_MSB:`MEI_FLG_LSB];
  assign thr_word = word[`MEI_THR_MSB:0];

  sequence idx_seen;
    st_r.idx_armed && !q_a && !q_b && !q_idx_n;
  endsequence
  sequence idx_taken;
    st_r.flags[`MEI_FLG_INDEX] && !st_r.idx_armed;
  endsequence
  // Last data byte of a command taken
  sequence word_done;
    wr_fall && st_r.busy_cnt == 8'h00 && q_ps_n && st_r.left == 3'h1;
  endsequence

  home_zero_a: assert property (cmd_byte && st_r.busy_cnt == 8'h00 && // [R1]
    q_d == `MEI_CMD_HOME |=> abs_pos == 32'h0000_0000)
    else $error("home did not zero position");
  idx_capture_a: assert property (idx_seen |=> idx_taken ##0 // [R5] [R6]
    index_pos == $past(st_r.abs_pos))
    else $error("index capture wrong");
  irq_gated_a: assert property ((st_nxt.enable & st_nxt.flags) == 6'h00 // [R3]
    |=> !host_irq)
    else $error("interrupt raised while masked");
  flag_poll_a: assert property (set_v[`MEI_FLG_POSERR] |=> // [R4] [R16]
    status_byte[`MEI_FLG_POSERR + 1])
    else $error("status lost an event");
  err_flag_a: assert property (sample_tick && st_r.thr_valid && // [R8]
    err_mag > {2'b00, st_r.thresh} |=> st_r.flags[`MEI_FLG_POSERR])
    else $error("position error flag missed");
  stop_zero_a: assert property (st_nxt.stopped && !st_nxt.wide |=> // [R9] [R18]
    motor_out == `MEI_ZERO_NARROW)
    else $error("stopped motor not at zero code");
  busy_ignore_a: assert property (cmd_byte && st_r.busy_cnt != 8'h00 // [R19]
    |=> st_r.cmd == $past(st_r.cmd) && st_r.left == $past(st_r.left))
    else $error("command taken while busy");
  flag_sticky_a: assert property (1'b1 |=> // [R15] [R20]
    ($past(kept_v) & ~st_r.flags) == 6'h00)
    else $error("flag dropped without clear");
  bp_hit_a: assert property (sample_tick && st_r.bp_armed && // [R10]
    st_r.abs_pos == st_r.bp_pos |=> st_r.flags[`MEI_FLG_BREAK] ##1 1'b1)
    else $error("breakpoint flag missed");
  busy_rise_a: assert property (cmd_byte && st_r.busy_cnt == 8'h00 |=> // [R19]
    status_byte[0])
    else $error("busy not raised after command");
  enable_load_a: assert property (word_done ##0 // [R13] [R14]
    (st_r.cmd == `MEI_CMD_ENABLE) |=> st_r.enable == $past(low_field))
    else $error("enable word not loaded");
  thr_load_a: assert property (word_done ##0 // [R7] [R21]
    (st_r.cmd == `MEI_CMD_ERR_INT || st_r.cmd == `MEI_CMD_ERR_STOP) |=>
    st_r.thresh == $past(thr_word))
    else $error("threshold not loaded");
  flag_clear_a: assert property (drop_v != 6'h00 |=> // [R15]
    (st_r.flags & $past(drop_v)) == 6'h00)
    else $error("flag not cleared");
  set_wins_a: assert property (race_v != 6'h00 |=> // [R20]
    (st_r.flags & $past(race_v)) == $past(race_v))
    else $error("clear beat an arriving event");
endmodule : mei_ctrl

/* File: test/mei_host.sv */
// Host processor model driving the byte-wide command and data port.
// Assumes the device status byte is visible and busy sits in bit 0.
`timescale 1ns/1ps
module mei_host (
  // Clock and device status
  input wire logic ref_clk,
  input wire logic [7:0] status_byte,
  // Host port pins
  output logic host_wr_n,
  output logic host_ps_n,
  output logic [7:0] host_d
);
  // ****************************************
  // Idle pins
  // ****************************************
  initial begin
    host_wr_n = 1'b1;
    host_ps_n = 1'b1;
    host_d = 8'h5A;
  end

  // Bounded busy poll, the device drops bytes written while busy
  task automatic wait_ready;
    for (int n = 0; n < 400 && status_byte[0] !== 1'b0; n++) begin
      @(negedge ref_clk);
    end
  endtask : wait_ready

  // One strobe; data set up well ahead of the pin filter
  task automatic put_byte(input logic ps, input logic [7:0] b);
    @(negedge ref_clk);
    host_ps_n = ps;
    host_d = b;
    repeat (5) @(negedge ref_clk);
    host_wr_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    host_wr_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    host_d = ~b; // Released bus never shows the stale byte
  endtask : put_byte

  // Command then its words, busy checked before each pair
  task automatic send(input logic [7:0] code, input int nb, input logic [31:0] data);
    wait_ready();
    put_byte(1'b0, code);
    wait_ready();
    for (int i = nb - 1; i >= 0; i--) begin
      put_byte(1'b1, data[8*i +: 8]);
      if (i % 2 == 0) wait_ready();
    end
  endtask : send
endmodule : mei_host

/* File: test/test_motion_event_interrupt_control.sv */
// Self-checking bench for the event flag and interrupt controller.
// Assumes mei_cfg.svh on the include path; host model drives the port.
`timescale 1ns/1ps
`include "mei_cfg.svh"
module test_motion_event_interrupt_control;
  typedef struct packed {
    logic [2:0] kind;
    logic [31:0] val;
  } mei_note_t;
  localparam int BUSY = 40;
  logic ref_clk, reset_n, host_wr_n, host_ps_n, enc_a, enc_b, enc_idx_n;
  logic sample_tick, traj_done, wrap_evt, host_irq, home_evt;
  logic [7:0] host_d, status_byte;
  logic signed [15:0] pos_error;
  logic [31:0] target_pos, index_pos, abs_pos, val;
  logic [11:0] motor_in, motor_out;
  logic [6:1] exp_f;
  logic [14:0] thr;
  mei_note_t notes[$];
  mei_note_t nt;
  int err_count = 0;
  int n_tests = 0;
  int n_home = 0;

  // Home pulses, counted at the falling edge where they are settled
  always @(negedge ref_clk) begin
    if (home_evt === 1'b1) begin
      n_home++;
    end
  end

  // ****************************************
  // Design and host
  // ****************************************
  mei_ctrl #(.BUSY_CYC(BUSY)) mei_ctrl_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .host_wr_n(host_wr_n), .host_ps_n(host_ps_n), .host_d(host_d), .enc_a(enc_a),
    .enc_b(enc_b), .enc_idx_n(enc_idx_n), .sample_tick(sample_tick),
    .pos_error(pos_error), .target_pos(target_pos), .motor_in(motor_in),
    .traj_done(traj_done), .wrap_evt(wrap_evt), .status_byte(status_byte),
    .host_irq(host_irq), .index_pos(index_pos), .abs_pos(abs_pos),
    .home_evt(home_evt), .motor_out(motor_out));
  mei_host mei_host_i (.ref_clk(ref_clk), .status_byte(status_byte),
    .host_wr_n(host_wr_n), .host_ps_n(host_ps_n), .host_d(host_d));

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Checking
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic note(input logic [2:0] k, input logic [31:0] v);
    notes.push_back({k, v});
    @(negedge ref_clk);
  endtask : note

  // Oldest note against the output it names, after edge updates land
  always @(posedge ref_clk) begin
    #1;
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt.kind)
        3'h0: check({25'h0, status_byte[7:1]}, nt.val);
        3'h1: check({31'h0, host_irq}, nt.val);
        3'h2: check(index_pos, nt.val);
        3'h3: check(abs_pos, nt.val);
        3'h5: check(n_home, nt.val);
        3'h6: check({31'h0, status_byte[0]}, nt.val);
        default: check({20'h0, motor_out}, nt.val);
      endcase
    end
  end

  task automatic end_sim;
    $display("Counts: %0d compared, %0d mismatched", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // Hang guard, several times the expected run
  initial begin
    #(40 * 60000);
    err_count++;
    end_sim();
  end

  // ****************************************
  // Stimulus helpers
  // ****************************************
  task automatic tick;
    @(negedge ref_clk);
    sample_tick = 1'b1;
    @(negedge ref_clk);
    sample_tick = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : tick

  // Encoder pins held long enough to pass the filter
  task automatic enc(input logic a, input logic b, input logic i);
    @(negedge ref_clk);
    enc_a = a;
    enc_b = b;
    enc_idx_n = i;
    repeat (8) @(negedge ref_clk);
  endtask : enc

  task automatic cmd(input logic [7:0] c, input int nb, input logic [31:0] d);
    mei_host_i.send(c, nb, d);
    repeat (4) @(negedge ref_clk);
  endtask : cmd

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {reset_n, sample_tick, traj_done, wrap_evt, enc_a, enc_b} = 6'h0;
    enc_idx_n = 1'b1;
    pos_error = 16'sh0;
    target_pos = 32'h0;
    motor_in = 12'h000;
    exp_f = 6'h00;
    void'($urandom(32'h9DB713F8));
    repeat (15) @(negedge ref_clk);
    note(3'h4, 32'h80);
    reset_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    note(3'h0, 32'h0);
    enc(1'b0, 1'b1, 1'b1);
    enc(1'b1, 1'b1, 1'b1);
    enc(1'b1, 1'b0, 1'b1);
    enc(1'b0, 1'b0, 1'b1);
    note(3'h3, 32'h4);
    cmd(`MEI_CMD_HOME, 0, 0);
    note(3'h3, 32'h0);
    note(3'h5, 32'h1);
    $display("Test home done");
    // Second command lands inside busy and must vanish
    mei_host_i.put_byte(1'b0, `MEI_CMD_NARROW);
    mei_host_i.put_byte(1'b0, 8'h3F);
    note(3'h6, 32'h1);
    note(3'h0, 32'h0);
    cmd(8'h3F, 0, 0);
    note(3'h6, 32'h0);
    exp_f[1] = 1'b1;
    note(3'h0, {26'h0, exp_f});
    $display("Test busy done");
    cmd(`MEI_CMD_ARM_IDX, 0, 0);
    enc(1'b1, 1'b0, 1'b1);
    enc(1'b1, 1'b0, 1'b0);
    note(3'h0, {26'h0, exp_f});
    enc(1'b1, 1'b0, 1'b1);
    enc(1'b1, 1'b1, 1'b1);
    enc(1'b0, 1'b1, 1'b1);
    enc(1'b0, 1'b0, 1'b1);
    enc(1'b0, 1'b0, 1'b0);
    enc(1'b0, 1'b0, 1'b1);
    exp_f[3] = 1'b1;
    note(3'h0, {26'h0, exp_f});
    note(3'h2, 32'hFFFFFFFC);
    $display("Test index done");
    thr = 15'($urandom) & 15'h7FFE;
    cmd(`MEI_CMD_ERR_INT, 2, {17'h0, thr});
    pos_error = {1'b0, thr};
    tick();
    note(3'h0, {26'h0, exp_f});
    pos_error = ~{1'b0, thr};
    note(3'h0, {26'h0, exp_f});
    tick();
    exp_f[5] = 1'b1;
    note(3'h0, {26'h0, exp_f});
    $display("Test error threshold done");
    cmd(`MEI_CMD_BP_ABS, 4, 32'h5);
    tick();
    note(3'h0, {26'h0, exp_f});
    cmd(`MEI_CMD_BP_ABS, 4, 32'hFFFFFFFC);
    tick();
    exp_f[6] = 1'b1;
    note(3'h0, {26'h0, exp_f});
    cmd(`MEI_CMD_CLEAR, 2, 32'hFFBF);
    exp_f[6] = 1'b0;
    note(3'h0, {26'h0, exp_f});
    target_pos = $urandom & 32'h0FFFFFFF;
    val = 32'hFFFFFFFC - target_pos;
    cmd(`MEI_CMD_BP_REL, 4, val);
    tick();
    exp_f[6] = 1'b1;
    note(3'h0, {26'h0, exp_f});
    $display("Test breakpoint done");
    @(negedge ref_clk);
    {traj_done, wrap_evt} = 2'b11;
    @(negedge ref_clk);
    {traj_done, wrap_evt} = 2'b00;
    repeat (2) @(negedge ref_clk);
    exp_f = 6'h3F;
    note(3'h0, {26'h0, exp_f});
    note(3'h1, 32'h0);
    // One enable bit at a time, then clear only that flag
    for (int i = 1; i <= 6; i++) begin
      cmd(`MEI_CMD_ENABLE, 2, 32'hFF81 | (32'h1 << i));
      note(3'h1, 32'h1);
      cmd(`MEI_CMD_CLEAR, 2, 32'hFFFF & ~(32'h1 << i));
      exp_f[i] = 1'b0;
      note(3'h0, {26'h0, exp_f});
      note(3'h1, 32'h0);
    end
    $display("Test mask and clear done");
    motor_in = 12'($urandom);
    cmd(`MEI_CMD_ERR_STOP, 2, 32'h0100);
    note(3'h4, {20'h0, motor_in});
    pos_error = 16'sh0200;
    tick();
    exp_f[5] = 1'b1;
    note(3'h0, {26'h0, exp_f});
    note(3'h4, 32'h80);
    cmd(`MEI_CMD_WIDE, 0, 0);
    note(3'h4, 32'h800);
    cmd(`MEI_CMD_START, 0, 0);
    note(3'h4, {20'h0, motor_in});
    $display("Test stop done");
    repeat (3) @(negedge ref_clk);
    end_sim();
  end
endmodule : test_motion_event_interrupt_control
